// [core/aopc_port.v]
// Contract
// - High selects straight binary, low inverts MSB
// - Fast select only gives fastest mode
// - Low power select only gives reduced power
// - Port select low parallel, high serial
// - Data bits 0 to 3 always outputs
// - Bits 4-6 outputs parallel, inputs serial
// - Internal clock source drives serial clock out
// - Clock invert flips serial clock and edges
// - Serial result shifted MSB first, formatted
`include "aopc_consts.vh"

module aopc_port
#(
  parameter [15:0] FAST_GAP_CYCLES = `AOPC_FAST_GAP_CYC
)
(
  input wire mclk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire conv_done_i,
  input wire [15:0] conv_result_i,
  output wire [15:0] d_o,
  output wire [2:0] d_oe_n_o,
  input wire [2:0] d_cfg_i,
  input wire sclk_i,
  output wire sclk_o,
  output wire sclk_oe_n_o,
  output wire frame_sync_o,
  output wire [2:0] mode_o
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_LOW = 4'h2;
  localparam [3:0] ST_HIGH = 4'h4;
  localparam [3:0] ST_EXT = 4'h8;
  localparam [7:0] SCLK_HALF = `AOPC_SCLK_HALF_CYC;

  function [15:0] fmt_result;
    input [15:0] raw;
    input ob;
    begin
      if (ob)
        fmt_result = raw;
      else
        fmt_result = {~raw[15], raw[14:0]};
    end
  endfunction

  function [2:0] mode_decode;
    input fast;
    input lowpwr;
    begin
      if (fast && !lowpwr)
        mode_decode = `AOPC_MODE_FAST;
      else if (lowpwr && !fast)
        mode_decode = `AOPC_MODE_LOWPWR;
      else
        mode_decode = `AOPC_MODE_NORMAL;
    end
  endfunction

  // Pins from the far side pass two flip-flops first
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;
  assign pin_raw = {sclk_i, d_cfg_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      aopc_sync2 u_sync
      (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i(pin_raw[gi]),
        .sync_o(pin_sync[gi])
      );
    end
  endgenerate

  wire cfg_ext_clk;
  wire cfg_sync_inv;
  wire cfg_sclk_inv;
  wire sclk_s;
  assign cfg_ext_clk = pin_sync[0];
  assign cfg_sync_inv = pin_sync[1];
  assign cfg_sclk_inv = pin_sync[2];
  assign sclk_s = pin_sync[3];

  reg [`AOPC_CTRL_W-1:0] ctrl_q;
  reg [2:0] mode_q;
  reg unsup_q;
  reg stale_q;
  reg [15:0] gap_q;
  reg gap_arm_q;
  reg [15:0] result_q;
  reg [15:0] d_q;
  reg [2:0] d_oe_n_q;
  reg ack_q;
  reg [31:0] dat_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [15:0] shift_q;
  reg [4:0] bits_q;
  reg [7:0] div_q;
  reg sclk_int_q;
  reg sclk_s_q;
  reg frm_inv_clk_q;
  reg frm_inv_sync_q;
  reg sclk_out_q;
  reg sclk_oe_n_q;
  reg fsync_q;

  wire ctl_ob;
  wire ctl_serial;
  wire [15:0] fmt_now;
  assign ctl_ob = ctrl_q[`AOPC_CTRL_OB_BIT];
  assign ctl_serial = ctrl_q[`AOPC_CTRL_SERIAL_BIT];
  assign fmt_now = fmt_result(conv_result_i, ctl_ob);

  // Wishbone: ack one cycle after the request, write lands on the next edge, while ack is high
  wire wb_req;
  wire wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && ack_q && wb_sel_i[0];

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `AOPC_ADR_CTRL:
        rd_mux = {28'h0000000, ctrl_q};
      `AOPC_ADR_STATUS:
        rd_mux = {21'h000000, cfg_sclk_inv, cfg_sync_inv, cfg_ext_clk,
                  2'h0, (state_q != ST_IDLE), stale_q, unsup_q, mode_q};
      `AOPC_ADR_RESULT:
        rd_mux = {16'h0000, result_q};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_req && !ack_q;
      if (wb_req && !ack_q)
        dat_q <= rd_mux;
    end
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      ctrl_q <= `AOPC_CTRL_RST;
    else if (wb_wr && wb_adr_i == `AOPC_ADR_CTRL)
      ctrl_q <= wb_dat_i[`AOPC_CTRL_W-1:0];
  end

  // Speed mode; the both-high case falls back to normal and is flagged
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      mode_q <= `AOPC_MODE_NORMAL;
      unsup_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_decode(ctrl_q[`AOPC_CTRL_FAST_BIT],
                            ctrl_q[`AOPC_CTRL_LOWPWR_BIT]);
      unsup_q <= ctrl_q[`AOPC_CTRL_FAST_BIT] &&
                 ctrl_q[`AOPC_CTRL_LOWPWR_BIT];
    end
  end

  // Watch the host's pacing in the fastest mode; a late start only
  // raises a sticky flag, the block itself keeps converting.
  wire gap_hit;
  assign gap_hit = gap_arm_q && (gap_q == FAST_GAP_CYCLES) &&
                   (mode_q == `AOPC_MODE_FAST);

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      gap_q <= 16'h0000;
      gap_arm_q <= 1'b0;
    end
    else if (mode_q != `AOPC_MODE_FAST)
    begin
      gap_q <= 16'h0000;
      gap_arm_q <= 1'b0;
    end
    else if (conv_done_i)
    begin
      gap_q <= 16'h0000;
      gap_arm_q <= 1'b1;
    end
    else if (gap_arm_q && gap_q != FAST_GAP_CYCLES)
      gap_q <= gap_q + 16'h0001;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      stale_q <= 1'b0;
    else if (gap_hit)
      stale_q <= 1'b1;
    else if (wb_wr && wb_adr_i == `AOPC_ADR_STATUS &&
             wb_dat_i[`AOPC_ST_STALE_BIT])
      stale_q <= 1'b0;
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
      result_q <= `AOPC_RES_RST;
    else if (conv_done_i)
      result_q <= fmt_now;
  end

  // Serial frame
  wire ext_edge;
  wire sclk_lvl;
  assign sclk_lvl = sclk_s ^ frm_inv_clk_q;
  assign ext_edge = sclk_lvl && !(sclk_s_q ^ frm_inv_clk_q);
  wire frame_start;
  assign frame_start = conv_done_i && ctl_serial && state_q == ST_IDLE;
  wire div_done;
  assign div_done = (div_q == SCLK_HALF - 8'h01);
  wire last_bit;
  assign last_bit = (bits_q == `AOPC_FRAME_BITS - 5'h01);

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (frame_start)
          state_d = cfg_ext_clk ? ST_EXT : ST_LOW;
      ST_LOW:
        if (div_done)
          state_d = ST_HIGH;
      ST_HIGH:
        if (div_done)
          state_d = last_bit ? ST_IDLE : ST_LOW;
      ST_EXT:
        if (ext_edge && last_bit)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      shift_q <= `AOPC_RES_RST;
      bits_q <= 5'h00;
      div_q <= 8'h00;
      sclk_int_q <= 1'b0;
      sclk_s_q <= 1'b0;
      frm_inv_clk_q <= 1'b0;
      frm_inv_sync_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sclk_s_q <= sclk_s;
      if (state_q == ST_IDLE || div_done)
        div_q <= 8'h00;
      else
        div_q <= div_q + 8'h01;
      case (state_q)
        ST_IDLE:
        begin
          sclk_int_q <= 1'b0;
          bits_q <= 5'h00;
          // Pins are tracked while idle so the resting levels follow
          // them, and frozen during a frame so a word is never torn.
          frm_inv_clk_q <= cfg_sclk_inv;
          frm_inv_sync_q <= cfg_sync_inv;
          if (frame_start)
            shift_q <= fmt_now;
        end
        ST_LOW:
          if (div_done)
            sclk_int_q <= 1'b1;
        ST_HIGH:
          if (div_done)
          begin
            sclk_int_q <= 1'b0;
            bits_q <= bits_q + 5'h01;
            shift_q <= {shift_q[14:0], 1'b0};
          end
        ST_EXT:
          if (ext_edge)
          begin
            bits_q <= bits_q + 5'h01;
            shift_q <= {shift_q[14:0], 1'b0};
          end
        default:
          sclk_int_q <= 1'b0;
      endcase
    end
  end

  // Pin drive, all from flip-flops
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      d_q <= `AOPC_RES_RST;
      d_oe_n_q <= 3'h7;
      sclk_out_q <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      fsync_q <= 1'b0;
    end
    else
    begin
      if (ctl_serial)
      begin
        d_q <= {7'h00, shift_q[15], 4'h0, result_q[3:0]};
        d_oe_n_q <= 3'h7;
        // Registered state keeps sync up through the last high phase
        fsync_q <= (state_q != ST_IDLE) ^ frm_inv_sync_q;
        sclk_oe_n_q <= cfg_ext_clk;
        sclk_out_q <= sclk_int_q ^ frm_inv_clk_q;
      end
      else
      begin
        d_q <= result_q;
        d_oe_n_q <= 3'h0;
        fsync_q <= 1'b0;
        sclk_oe_n_q <= 1'b1;
        sclk_out_q <= 1'b0;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign d_o = d_q;
  assign d_oe_n_o = d_oe_n_q;
  assign sclk_o = sclk_out_q;
  assign sclk_oe_n_o = sclk_oe_n_q;
  assign frame_sync_o = fsync_q;
  assign mode_o = mode_q;

endmodule

// [core/aopc_consts.vh]
`ifndef AOPC_CONSTS_VH
`define AOPC_CONSTS_VH

// Clock rate of mclk_i
`define AOPC_CLK_HZ 10000000

// Register byte addresses (Wishbone, one aligned word each)
`define AOPC_ADR_CTRL 4'h0
`define AOPC_ADR_STATUS 4'h4
`define AOPC_ADR_RESULT 4'h8

// Control register fields
`define AOPC_CTRL_OB_BIT 0
`define AOPC_CTRL_FAST_BIT 1
`define AOPC_CTRL_LOWPWR_BIT 2
`define AOPC_CTRL_SERIAL_BIT 3
`define AOPC_CTRL_W 4
`define AOPC_CTRL_RST 4'h1

// Status register fields
`define AOPC_ST_MODE_LSB 0
`define AOPC_ST_UNSUP_BIT 3
`define AOPC_ST_STALE_BIT 4
`define AOPC_ST_SHIFT_BIT 5
`define AOPC_ST_CFG_LSB 8

// Mode codes, one-hot
`define AOPC_MODE_FAST 3'h1
`define AOPC_MODE_NORMAL 3'h2
`define AOPC_MODE_LOWPWR 3'h4

// Result width and serial frame length
`define AOPC_RES_W 16
`define AOPC_FRAME_BITS 5'h10
`define AOPC_RES_RST 16'h0000

// Internal serial clock half period in mclk cycles (100 ns)
`define AOPC_SCLK_HALF_CYC 8'h01

// Longest gap between conversions in the fastest mode, 1 ms
`define AOPC_FAST_GAP_CYC 16'h2710

`endif

// [core/aopc_sync2.v]
module aopc_sync2
(
  input wire mclk_i,
  input wire rst_i,
  input wire async_i,
  output wire sync_o
);

  reg meta_q;
  reg sync_q;

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// [dv/aopc_port_sva.sv]
module aopc_port_sva
#(
  parameter [15:0] FAST_GAP_CYCLES = 16'h2710
)
(
  input wire mclk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire conv_done_i,
  input wire [15:0] conv_result_i,
  input wire [15:0] d_o,
  input wire [2:0] d_oe_n_o,
  input wire [2:0] d_cfg_i,
  input wire sclk_i,
  input wire sclk_o,
  input wire sclk_oe_n_o,
  input wire frame_sync_o,
  input wire [2:0] mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctrl_q;
  logic [2:0] exp_mode;
  // Shadow of the control word, taken at the acknowledged write
  always @(posedge mclk_i)
    if (rst_i)
      ctrl_q <= 4'h1;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
             wb_sel_i[0] && wb_adr_i == 4'h0)
      ctrl_q <= wb_dat_i[3:0];
  assign exp_mode = ctrl_q[2:1] == 2'h1 ? 3'h1 :
                    ctrl_q[2:1] == 2'h2 ? 3'h4 : 3'h2;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_MODE: assert property (
    $stable(ctrl_q)[*3] |-> mode_o == exp_mode)
    else $error("mode output wrong");
  AST_PORT: assert property (
    $stable(ctrl_q)[*3] |-> d_oe_n_o == {3{ctrl_q[3]}})
    else $error("pin direction wrong");
  AST_LOWB: assert property (
    conv_done_i |-> ##2 d_o[3:0] == $past(conv_result_i[3:0], 2))
    else $error("low data bits wrong");
  AST_FMT: assert property (
    conv_done_i && !ctrl_q[3] |-> ##2
    d_o == ($past(conv_result_i, 2) ^ {~$past(ctrl_q[0], 2), 15'h0}))
    else $error("parallel word wrong");
  AST_SCK: assert property (
    (ctrl_q[3] && !d_cfg_i[0])[*8] |-> !sclk_oe_n_o)
    else $error("serial clock not driven");
  AST_SYNC: assert property (
    ctrl_q[3] && !d_cfg_i[0] && conv_done_i && frame_sync_o == d_cfg_i[1]
    |-> ##2 frame_sync_o != d_cfg_i[1])
    else $error("frame sync level wrong");
  AST_REST: assert property (
    ctrl_q[3] && !sclk_oe_n_o && $changed(frame_sync_o)
    |-> sclk_o == d_cfg_i[2])
    else $error("serial clock rest level wrong");
  AST_MSB: assert property (
    ctrl_q[3] && !d_cfg_i[0] && conv_done_i && frame_sync_o == d_cfg_i[1]
    |-> ##2 d_o[8] == ($past(conv_result_i[15], 2) ~^ $past(ctrl_q[0], 2)))
    else $error("first serial bit wrong");
endmodule

// [dv/aopc_host.sv]
module aopc_host
(
  input wire logic run_i,
  input wire logic inv_i,
  input wire logic sdo_i,
  output wire logic sclk_o,
  output logic [15:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  assign sclk_o = lvl ^ inv_i;
  initial
  begin
    lvl = 1'h0;
    word_o = 16'h0;
  end
  // Clock stands still between frames; a bit is taken just before
  // each active edge, since the device moves on only after it
  always @(posedge run_i)
    for (int k = 0; k < 16; k++)
    begin
      #400;
      word_o = {word_o[14:0], sdo_i};
      lvl = 1'h1;
      #400;
      lvl = 1'h0;
    end
endmodule

// [dv/aopc_port_tb.sv]
module aopc_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, conv_done_i, run;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] conv_result_i, d_o, w, hword;
  logic [2:0] cfg, d_oe_n_o, d_cfg_i, mode_o;
  logic wb_ack_o, sclk_i, sclk_o, sclk_oe_n_o, frame_sync_o, hclk;
  int num_errors, checked, i, nb, act;
  aopc_port #(.FAST_GAP_CYCLES(16'h0032)) aopc_port_i (.*);
  aopc_host aopc_host_i (.run_i(run), .inv_i(cfg[2]), .sdo_i(d_o[8]),
    .sclk_o(hclk), .word_o(hword));
  // Shared pins resolve from the device's enables alone
  assign d_cfg_i = (d_oe_n_o & cfg) | (~d_oe_n_o & d_o[6:4]);
  assign sclk_i = sclk_oe_n_o ? hclk : sclk_o;
  initial
  begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= wr;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1)
    begin
      chk(wb_ack_o, 1'h1);
      stop_test();
    end
    else
      @(posedge mclk_i);
  endtask
  task automatic conv(input logic [15:0] r);
    conv_result_i <= r;
    conv_done_i <= 1'h1;
    @(posedge mclk_i);
    conv_done_i <= 1'h0;
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] r,
                                      input logic ob);
    fmt = r ^ {~ob, 15'h0};
  endfunction
  task automatic rx;
    logic p, c;
    p = 1'h0;
    nb = 0;
    act = 0;
    repeat (60)
    begin
      @(posedge mclk_i);
      c = sclk_o ^ cfg[2];
      if (c && !p)
      begin
        w = {w[14:0], d_o[8]};
        nb++;
        act += (frame_sync_o != cfg[1]);
      end
      p = c;
    end
  endtask
  initial
  begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, conv_done_i, run} = 5'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    conv_result_i = 16'h0;
    cfg = 3'h0;
    num_errors = 0;
    checked = 0;
    wt(5);
    rst_i <= 1'h0;
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h1);
    bus(1'h0, 4'h4, 32'h0);
    chk(q, 32'h2);
    bus(1'h0, 4'hC, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
      bus(1'h1, 4'h0, 32'h1 | (i << 1));
      bus(1'h0, 4'h4, 32'h0);
      chk(q[3:0], {i == 3, i == 2, i == 0 || i == 3, i == 1});
      chk(mode_o, {i == 2, i == 0 || i == 3, i == 1});
    end
    // Fast mode left idle past the shortened gap
    bus(1'h1, 4'h0, 32'h3);
    conv(16'h1234);
    wt(60);
    bus(1'h0, 4'h4, 32'h0);
    chk(q[4], 1'h1);
    // Still late in fast mode: the set beats the clear
    bus(1'h1, 4'h4, 32'h10);
    bus(1'h0, 4'h4, 32'h0);
    chk(q[4], 1'h1);
    $display("mode test done");
    for (i = 0; i < 2; i++)
    begin
      bus(1'h1, 4'h0, i);
      conv(16'h8A5C);
      wt(2);
      chk(d_o, fmt(16'h8A5C, i[0]));
      chk(d_oe_n_o, 3'h0);
      bus(1'h0, 4'h8, 32'h0);
      chk(q, fmt(16'h8A5C, i[0]));
    end
    bus(1'h1, 4'h4, 32'h10);
    bus(1'h0, 4'h4, 32'h0);
    chk(q[4], 1'h0);
    $display("parallel test done");
    // Polarity and inversion never change in the same step
    for (i = 0; i < 4; i++)
    begin
      cfg <= {i[1], i[1] ^ i[0], 1'h0};
      bus(1'h1, 4'h0, 32'h8 | i[0]);
      wt(8);
      chk(sclk_oe_n_o, 1'h0);
      chk(d_oe_n_o, 3'h7);
      conv(16'hC3A5 + i);
      rx();
      chk(w, fmt(16'hC3A5 + i, i[0]));
      chk(nb, 16);
      chk(act, 16);
      chk(frame_sync_o, cfg[1]);
      chk(sclk_o, cfg[2]);
      chk(d_o[3:0], 4'h5 + i);
    end
    $display("serial test done");
    for (i = 0; i < 2; i++)
    begin
      cfg <= {i[0], 2'h1};
      bus(1'h1, 4'h0, 32'h9);
      wt(8);
      chk(sclk_oe_n_o, 1'h1);
      conv(16'h5AC3 ^ i);
      wt(3);
      run <= 1'h1;
      wt(140);
      run <= 1'h0;
      chk(hword, fmt(16'h5AC3 ^ i, 1'h1));
    end
    $display("external clock test done");
    rst_i <= 1'h1;
    wt(2);
    rst_i <= 1'h0;
    bus(1'h0, 4'h0, 32'h0);
    chk(q, 32'h1);
    $display("second reset test done");
    stop_test();
  end
endmodule
bind aopc_port aopc_port_sva #(.FAST_GAP_CYCLES(FAST_GAP_CYCLES))
  aopc_port_sva_i (.*);
